// >>> src/dma_front_end_params.svh
// Register map, field positions, reset values and sizes of the DMA front end
`ifndef DMA_FRONT_END_PARAMS_SVH
`define DMA_FRONT_END_PARAMS_SVH

`define REG_CONFIG        8'h00
`define REG_TX_CONFIG     8'h04
`define REG_RX_CONFIG     8'h08
`define REG_IRQ_PENDING   8'h0C
`define REG_IRQ_MASK      8'h10
`define REG_TX_ADDR       8'h14
`define REG_RX_ADDR       8'h18
`define REG_STATUS        8'h1C
`define REG_CONTROL       8'h20

`define CFG_BYTE_ORDER_BIT  0
`define CFG_HOLD_LSB        8
`define CFG_RESET           32'h0000_0000
`define TRANSMIT_CONFIG_REG_RESET         32'h0008_1010
`define RECEIVE_CONFIG_REG_RESET         32'h0008_0008
`define FLD_FILL_LSB        0
`define FLD_DRAIN_LSB       8
`define FLD_BURST_LSB       16
`define CTRL_TX_EN_BIT      0
`define CTRL_RX_EN_BIT      1

`define FIFO_WORDS          512
`define PKT_SLOTS           4
`define MAX_BURST_WORDS     128
`define IRQ_BITS            4
`define IRQ_TX_FETCHED      0
`define IRQ_TX_SENT         1
`define IRQ_RX_DONE         2
`define IRQ_BUS_LOST        3

`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

// >>> src/dma_front_end_pkg.sv
// Types shared by the DMA front end and its users
package dma_front_end_pkg;

    typedef struct packed {
        logic        last;
        logic [31:0] data;
    } mac_word_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_REQ,
        BUS_XFER,
        BUS_END
    } bus_state_t;

    function automatic logic [31:0] order_bytes(input logic [31:0] w, input logic big);
        order_bytes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    endfunction : order_bytes

endpackage : dma_front_end_pkg

// >>> src/dma_front_end.sv
// Bus-master DMA front end: data FIFOs, bus ownership, interrupts, AXI4-Lite registers
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dma_front_end_params.svh"

module dma_front_end #(
    parameter int DEPTH     = `FIFO_WORDS,
    parameter int PKT_SLOTS = `PKT_SLOTS
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [7:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [7:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic                            bus_req_n,
    input  wire logic                       bus_gnt_n,
    output logic                            frame_n,
    output dma_front_end_pkg::mem_req_t     mem_req,
    input  wire logic                       mem_ready,
    input  wire logic [31:0]                mem_rdata,
    input  wire logic                       mem_rlast,
    output dma_front_end_pkg::mac_word_t    tx_mac_word,
    output logic                            tx_mac_valid,
    input  wire logic                       tx_mac_ready,
    input  wire dma_front_end_pkg::mac_word_t rx_mac_word,
    input  wire logic                       rx_mac_valid,
    output logic                            rx_mac_ready,
    output logic                            host_irq_n,
    output logic                            host_irq_n_oe
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [2:0]  SLOTS_C = 3'(PKT_SLOTS);

    // Registers
    logic [31:0] config_q, transmit_config_reg, receive_config_reg, tx_addr_q, rx_addr_q;
    logic [1:0]  control_q;
    logic [`IRQ_BITS-1:0] irq_pending_reg, irq_enable_mask_reg, irq_event;
    logic byte_order_select;
    logic [7:0] bus_hold_count_setting, tx_fill_level, tx_drain_level, rx_drain_level;
    logic [7:0] tx_max_burst_size, rx_max_burst_size;
    assign byte_order_select      = config_q[`CFG_BYTE_ORDER_BIT];
    assign bus_hold_count_setting = config_q[`CFG_HOLD_LSB +: 8];
    assign tx_fill_level          = transmit_config_reg[`FLD_FILL_LSB +: 8];
    assign tx_drain_level         = transmit_config_reg[`FLD_DRAIN_LSB +: 8];
    assign tx_max_burst_size      = transmit_config_reg[`FLD_BURST_LSB +: 8];
    assign rx_drain_level         = receive_config_reg[`FLD_DRAIN_LSB +: 8];
    assign rx_max_burst_size      = receive_config_reg[`FLD_BURST_LSB +: 8];

    // Grant comes from the arbiter outside this clock's logic
    logic gnt_meta_q, gnt_n_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gnt_meta_q <= 1'b1;
            gnt_n_q    <= 1'b1;
        end else begin
            gnt_meta_q <= bus_gnt_n;
            gnt_n_q    <= gnt_meta_q;
        end
    end

    // FIFO storage: words with their last flag in bit 32, descriptors never land here
    logic [32:0]  tx_mem [DEPTH];
    logic [32:0]  rx_mem [DEPTH];
    logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [AW:0]   tx_cnt_q, rx_cnt_q;
    logic [2:0]    tx_pkts_q, rx_pkts_q;

    dma_front_end_pkg::bus_state_t state_q;
    logic        dir_rx_q, stop_q;
    logic [7:0]  hold_q, burst_cnt_q, burst_lim_q;
    logic        beat, issue, tx_push, tx_pop, rx_push, rx_pop, tx_want, rx_want, stop_now;
    logic [AW:0] tx_free;
    logic [7:0]  tx_lim, rx_lim;
    logic        aw_held_q, w_held_q, wr_en, rd_en, pend_read, tx_load;
    logic [7:0]  aw_addr_q;
    logic [31:0] wr_data, w_data_q, rd_value;
    logic [3:0]  w_strb_q;

    assign beat    = mem_req.valid && mem_ready;
    assign tx_free = DEPTH_C - tx_cnt_q;
    // Zero burst field means the largest burst the bus allows
    assign tx_lim  = (tx_max_burst_size == 8'h00 || tx_max_burst_size > 8'(`MAX_BURST_WORDS))
                     ? 8'(`MAX_BURST_WORDS) : tx_max_burst_size;
    assign rx_lim  = (rx_max_burst_size == 8'h00 || rx_max_burst_size > 8'(`MAX_BURST_WORDS))
                     ? 8'(`MAX_BURST_WORDS) : rx_max_burst_size;
    assign tx_want = control_q[`CTRL_TX_EN_BIT] && tx_pkts_q < SLOTS_C
                     && tx_free >= (AW+1)'(tx_fill_level) && tx_free != '0;
    assign rx_want = control_q[`CTRL_RX_EN_BIT] && rx_cnt_q != '0
                     && (rx_cnt_q >= (AW+1)'(rx_drain_level) || rx_pkts_q != 3'h0);

    // Next beat may be loaded only while the burst has not met a stop condition
    assign stop_now = stop_q || burst_cnt_q == burst_lim_q
                      || (gnt_n_q && hold_q == 8'h00)
                      || (!dir_rx_q && beat && mem_rlast)
                      || (dir_rx_q && rx_cnt_q == '0);
    assign issue   = state_q == dma_front_end_pkg::BUS_XFER && !stop_now
                     && (!mem_req.valid || mem_ready);
    assign tx_push = beat && !mem_req.write;
    assign rx_pop  = issue && dir_rx_q;
    assign tx_pop  = tx_mac_valid && tx_mac_ready;
    assign rx_push = rx_mac_valid && rx_mac_ready;

    // Bus ownership
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q     <= dma_front_end_pkg::BUS_IDLE;
            dir_rx_q    <= 1'b0;
            bus_req_n   <= 1'b1;
            frame_n     <= 1'b1;
            burst_lim_q <= 8'h00;
        end else begin
            unique case (state_q)
                dma_front_end_pkg::BUS_IDLE: begin
                    if (rx_want || tx_want) begin
                        dir_rx_q    <= rx_want;
                        burst_lim_q <= rx_want ? rx_lim
                                     : (tx_free < (AW+1)'(tx_lim) ? 8'(tx_free) : tx_lim);
                        bus_req_n   <= 1'b0;
                        state_q     <= dma_front_end_pkg::BUS_REQ;
                    end
                end
                dma_front_end_pkg::BUS_REQ: begin
                    if (!gnt_n_q) begin
                        frame_n <= 1'b0;
                        state_q <= dma_front_end_pkg::BUS_XFER;
                    end
                end
                dma_front_end_pkg::BUS_XFER: begin
                    if (stop_now && (!mem_req.valid || mem_ready)) begin
                        frame_n   <= 1'b1;
                        bus_req_n <= 1'b1;
                        state_q   <= dma_front_end_pkg::BUS_END;
                    end
                end
                dma_front_end_pkg::BUS_END: state_q <= dma_front_end_pkg::BUS_IDLE;
            endcase
        end
    end

    // Hold counter loads as frame goes low and counts down bus clocks
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_q <= 8'h00;
        end else if (state_q == dma_front_end_pkg::BUS_REQ && !gnt_n_q) begin
            hold_q <= bus_hold_count_setting;
        end else if (hold_q != 8'h00) begin
            hold_q <= hold_q - 8'h01;
        end
    end

    // Beats of the current burst
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_req     <= '0;
            burst_cnt_q <= 8'h00;
            stop_q      <= 1'b0;
            tx_addr_q   <= 32'h0000_0000;
            rx_addr_q   <= 32'h0000_0000;
        end else begin
            // Address writes must land in every bus state, so they sit outside this chain
            if (state_q == dma_front_end_pkg::BUS_REQ) begin
                burst_cnt_q <= 8'h00;
                stop_q      <= 1'b0;
            end else if (issue) begin
                burst_cnt_q   <= burst_cnt_q + 8'h01;
                mem_req.valid <= 1'b1;
                mem_req.write <= dir_rx_q;
                mem_req.addr  <= dir_rx_q ? rx_addr_q : tx_addr_q;
                mem_req.wdata <= dma_front_end_pkg::order_bytes(rx_mem[rx_rp_q][31:0],
                                                                byte_order_select);
                if (dir_rx_q && rx_mem[rx_rp_q][32]) begin
                    stop_q <= 1'b1;
                end
                if (dir_rx_q) begin
                    rx_addr_q <= rx_addr_q + 32'h4;
                end else begin
                    tx_addr_q <= tx_addr_q + 32'h4;
                end
            end else if (beat) begin
                mem_req.valid <= 1'b0;
            end
            if (beat && !mem_req.write && mem_rlast) begin
                stop_q <= 1'b1;
            end
            if (wr_en && aw_addr_q == `REG_TX_ADDR) begin
                tx_addr_q <= wr_data;
            end
            if (wr_en && aw_addr_q == `REG_RX_ADDR) begin
                rx_addr_q <= wr_data;
            end
        end
    end

    // Storage writes for both FIFOs, then transmit FIFO pointers and its packet count
    always_ff @(posedge aclk) begin
        if (tx_push) begin
            tx_mem[tx_wp_q] <= {mem_rlast,
                                dma_front_end_pkg::order_bytes(mem_rdata, byte_order_select)};
        end
        if (rx_push) begin
            rx_mem[rx_wp_q] <= {rx_mac_word.last, rx_mac_word.data};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_wp_q   <= '0;
            tx_rp_q   <= '0;
            tx_cnt_q  <= '0;
            tx_pkts_q <= 3'h0;
        end else begin
            if (tx_push) begin
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_load) begin
                tx_rp_q <= tx_rp_q + 1'b1;
            end
            tx_cnt_q  <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_load);
            tx_pkts_q <= tx_pkts_q + 3'(tx_push && mem_rlast)
                         - 3'(tx_pop && tx_mac_word.last);
        end
    end

    // Words go to the MAC once the drain level is met or a whole packet waits
    assign tx_load = tx_cnt_q != '0 && (!tx_mac_valid || tx_mac_ready)
                     && (tx_cnt_q >= (AW+1)'(tx_drain_level) || tx_pkts_q != 3'h0);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_mac_valid <= 1'b0;
            tx_mac_word  <= '0;
        end else if (tx_load) begin
            tx_mac_valid <= 1'b1;
            tx_mac_word  <= tx_mem[tx_rp_q];
        end else if (tx_pop) begin
            tx_mac_valid <= 1'b0;
        end
    end

    // Receive FIFO; a packet counter stands in for the status FIFO slots
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_wp_q      <= '0;
            rx_rp_q      <= '0;
            rx_cnt_q     <= '0;
            rx_pkts_q    <= 3'h0;
            rx_mac_ready <= 1'b0;
        end else begin
            if (rx_push) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_q <= rx_rp_q + 1'b1;
            end
            rx_cnt_q  <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
            rx_pkts_q <= rx_pkts_q + 3'(rx_push && rx_mac_word.last)
                         - 3'(rx_pop && rx_mem[rx_rp_q][32]);
            // Margin of two words covers the registered ready
            rx_mac_ready <= rx_cnt_q < DEPTH_C - (AW+1)'(2)
                            && rx_pkts_q + 3'(rx_push && rx_mac_word.last) < SLOTS_C;
        end
    end

    // Interrupt events
    assign irq_event[`IRQ_TX_FETCHED] = tx_push && mem_rlast;
    assign irq_event[`IRQ_TX_SENT]    = tx_pop && tx_mac_word.last;
    assign irq_event[`IRQ_RX_DONE]    = beat && mem_req.write && stop_q && burst_cnt_q != 8'h00
                                        && state_q == dma_front_end_pkg::BUS_XFER;
    assign irq_event[`IRQ_BUS_LOST]   = state_q == dma_front_end_pkg::BUS_XFER && gnt_n_q
                                        && !stop_now;

    // AXI4-Lite slave: address and data taken in either order, answer when both held
    assign wr_en     = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_data   = w_data_q;
    assign rd_en     = s_axi_arvalid && s_axi_arready;
    assign pend_read = rd_en && s_axi_araddr == `REG_IRQ_PENDING;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !wr_en;
            s_axi_wready  <= !w_held_q && !s_axi_wready && !wr_en;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= `REG_CONTROL)
                                ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Byte lanes honoured on the configuration registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction : merge

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_q            <= `CFG_RESET;
            transmit_config_reg <= `TRANSMIT_CONFIG_REG_RESET;
            receive_config_reg  <= `RECEIVE_CONFIG_REG_RESET;
            irq_enable_mask_reg <= '0;
            control_q           <= 2'b00;
        end else if (wr_en) begin
            unique case (aw_addr_q)
                `REG_CONFIG:    config_q <= merge(config_q, wr_data, w_strb_q);
                `REG_TX_CONFIG: transmit_config_reg <= merge(transmit_config_reg, wr_data, w_strb_q);
                `REG_RX_CONFIG: receive_config_reg <= merge(receive_config_reg, wr_data, w_strb_q);
                `REG_IRQ_MASK:  irq_enable_mask_reg <= wr_data[`IRQ_BITS-1:0];
                `REG_CONTROL:   control_q <= wr_data[1:0];
                default: ;
            endcase
        end
    end

    // A read clears all pending bits, but an event in that same cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pending_reg <= '0;
        end else begin
            irq_pending_reg <= (pend_read ? '0 : irq_pending_reg) | irq_event;
        end
    end

    always_comb begin
        unique case (s_axi_araddr)
            `REG_CONFIG:      rd_value = config_q;
            `REG_TX_CONFIG:   rd_value = transmit_config_reg;
            `REG_RX_CONFIG:   rd_value = receive_config_reg;
            `REG_IRQ_PENDING: rd_value = 32'(irq_pending_reg);
            `REG_IRQ_MASK:    rd_value = 32'(irq_enable_mask_reg);
            `REG_TX_ADDR:     rd_value = tx_addr_q;
            `REG_RX_ADDR:     rd_value = rx_addr_q;
            `REG_STATUS:      rd_value = {6'h00, 3'(rx_pkts_q), 3'(tx_pkts_q),
                                          10'(rx_cnt_q), 10'(tx_cnt_q)};
            `REG_CONTROL:     rd_value = 32'(control_q);
            default:          rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rd_en) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_value;
                s_axi_rresp  <= (s_axi_araddr[1:0] == 2'b00 && s_axi_araddr <= `REG_CONTROL)
                                ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Open-drain pin: driven low only, released otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            host_irq_n    <= 1'b1;
            host_irq_n_oe <= 1'b0;
        end else begin
            host_irq_n    <= 1'b0;
            host_irq_n_oe <= |(irq_pending_reg & irq_enable_mask_reg);
        end
    end

endmodule : dma_front_end
`default_nettype wire

// >>> verif/dma_front_end_properties.sv
// Port-level assertions for the DMA front end, bound to the top module
`timescale 1ns/1ps
`default_nettype none
module dma_front_end_checker (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid,
    input wire logic                        s_axi_bvalid,
    input wire logic                        s_axi_bready,
    input wire logic                        bus_req_n,
    input wire logic                        bus_gnt_n,
    input wire logic                        frame_n,
    input wire dma_front_end_pkg::mem_req_t mem_req,
    input wire logic                        mem_ready,
    input wire logic                        host_irq_n,
    input wire logic                        host_irq_n_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Beats taken since frame fell; cleared in the gap between bursts
    logic [7:0] beats_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || frame_n) beats_q <= 8'h00;
        else if (mem_req.valid && mem_ready) beats_q <= beats_q + 8'h01;
    end
    property p_irq_drive; host_irq_n_oe |-> !host_irq_n; endproperty
    a_irq_drive: assert property (p_irq_drive) else $error("irq enabled but pin high");
    property p_own_req; !frame_n |-> !bus_req_n; endproperty
    a_own_req: assert property (p_own_req) else $error("frame low without request");
    property p_release; $rose(frame_n) |-> bus_req_n; endproperty
    a_release: assert property (p_release) else $error("request kept after frame");
    property p_beat_owned; mem_req.valid |-> !frame_n; endproperty
    a_beat_owned: assert property (p_beat_owned) else $error("beat outside frame");
    property p_burst_max; mem_req.valid && mem_ready |-> beats_q < 8'h80; endproperty
    a_burst_max: assert property (p_burst_max) else $error("burst over 128 words");
    // Grant pin passes two sync flops, then one edge to drop frame
    property p_frame_gnt; $fell(frame_n) |-> !$past(bus_gnt_n, 3); endproperty
    a_frame_gnt: assert property (p_frame_gnt) else $error("frame without grant");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule : dma_front_end_checker
bind dma_front_end dma_front_end_checker u_dma_front_end_checker (.*);
`default_nettype wire

// >>> verif/pci_host_model.sv
// Host bus model: arbiter that may withdraw grant, memory with random wait states
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        bus_req_n,
    input wire dma_front_end_pkg::mem_req_t mem_req,
    output logic                            bus_gnt_n,
    output logic                            mem_ready,
    output logic [31:0]                     mem_rdata,
    output logic                            mem_rlast
);
    logic [31:0] mem [64];
    int          nwr;
    logic [31:0] pat;
    // Idle cycles show the inverse so stale data is never taken as valid
    assign pat       = mem_req.addr ^ 32'h5A5A_0000;
    assign mem_rdata = mem_ready ? pat : ~pat;
    assign mem_rlast = mem_ready ? (mem_req.addr[3:2] == 2'b11) : 1'b0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_gnt_n <= 1'b1;
            mem_ready <= 1'b0;
            nwr       <= 0;
        end else begin
            bus_gnt_n <= bus_req_n | ($urandom % 8 == 0);
            mem_ready <= ($urandom % 4 != 0);
            if (mem_req.valid && mem_ready && mem_req.write) begin
                mem[mem_req.addr[7:2]] <= mem_req.wdata;
                nwr <= nwr + 1;
            end
        end
    end
endmodule : pci_host_model
`default_nettype wire

// >>> verif/pci_master_fifo_dma_front_end_bench.sv
// Self-checking bench: registers, transmit fetch, receive store, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "dma_front_end_params.svh"
module pci_master_fifo_dma_front_end_bench;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, mem_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
    logic s_axi_rvalid, bus_req_n, bus_gnt_n, frame_n, mem_ready, mem_rlast;
    logic host_irq_n, host_irq_n_oe, tx_mac_valid, tx_mac_ready = 0;
    logic rx_mac_valid = 0, rx_mac_ready;
    dma_front_end_pkg::mem_req_t mem_req;
    dma_front_end_pkg::mac_word_t tx_mac_word, rx_mac_word = '0;
    int n_errors = 0, checked = 0;
    dma_front_end u_dma_front_end (.*);
    pci_host_model u_pci_host_model (.*);
    always #10 aclk = ~aclk;
    function automatic logic [31:0] swap(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= d; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
    endtask : rd
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        #1_000_000;
        n_errors++;
        complete_run();
    end
    initial begin
        logic [31:0] d, e, rxd [8];
        logic [1:0]  r;
        logic [7:0]  hold;
        logic [7:0]  ra [3] = '{`REG_CONFIG, `REG_TX_CONFIG, `REG_RX_CONFIG};
        logic [31:0] rv [3] = '{`CFG_RESET, `TRANSMIT_CONFIG_REG_RESET, `RECEIVE_CONFIG_REG_RESET};
        void'($urandom(32'hCFEF));
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 3; i++) begin
            rd(ra[i], d, r);
            chk(d, rv[i]);
        end
        rd(8'h24, d, r);
        chk(32'(r), 32'(`AXI_RESP_SLVERR));
        wr(8'h24, 32'h0);
        chk(32'(wr_resp), 32'(`AXI_RESP_SLVERR));
        hold = 8'($urandom);
        wr(`REG_CONFIG, {16'h0, hold, 8'h01});
        chk(32'(wr_resp), 32'(`AXI_RESP_OKAY));
        rd(`REG_CONFIG, d, r);
        chk(d & 32'hFF01, {16'h0, hold, 8'h01});
        $display("registers test done");
        wr(`REG_IRQ_MASK, 32'hF); wr(`REG_TX_ADDR, 32'h100); wr(`REG_CONTROL, 32'h1);
        // Random MAC stalls while words stream out in big endian order
        for (int k = 0; k < 8;) begin
            @(posedge aclk);
            if (tx_mac_valid && tx_mac_ready) begin
                e = (32'h100 + 4 * k) ^ 32'h5A5A_0000;
                chk(tx_mac_word.data, swap(e));
                chk(32'(tx_mac_word.last), 32'(k % 4 == 3));
                k++;
            end
            tx_mac_ready <= 1'($urandom);
        end
        tx_mac_ready <= 0;
        chk(32'(host_irq_n_oe), 32'h1);
        chk(32'(host_irq_n), 32'h0);
        rd(`REG_IRQ_PENDING, d, r);
        chk(d & 32'h3, 32'h3);
        wr(`REG_CONTROL, 32'h0);
        repeat (300) @(posedge aclk);
        rd(`REG_IRQ_PENDING, d, r);
        rd(`REG_IRQ_PENDING, d, r);
        chk(d, 32'h0);
        chk(32'(host_irq_n_oe), 32'h0);
        $display("transmit and interrupt test done");
        wr(`REG_CONFIG, {16'h0, hold, 8'h00}); wr(`REG_IRQ_MASK, 32'h0);
        wr(`REG_RX_ADDR, 32'h0); wr(`REG_CONTROL, 32'h2);
        for (int i = 0; i < 8; i++) begin
            rxd[i] = $urandom;
            rx_mac_word <= '{i == 7, rxd[i]};
            rx_mac_valid <= 1;
            do @(posedge aclk); while (!rx_mac_ready);
        end
        rx_mac_valid <= 0;
        for (int t = 0; t < 3000 && u_pci_host_model.nwr < 8; t++) @(posedge aclk);
        for (int i = 0; i < 8; i++) chk(u_pci_host_model.mem[i], rxd[i]);
        chk(32'(host_irq_n_oe), 32'h0);
        rd(`REG_IRQ_PENDING, d, r);
        chk(d & 32'h4, 32'h4);
        $display("receive test done");
        complete_run();
    end
endmodule : pci_master_fifo_dma_front_end_bench
`default_nettype wire
